// ===== rtl/rapu_pkg.sv
package rapu_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] RAPU_ADDR_SELECT    = 32'hE000ED98;
    localparam logic [31:0] RAPU_OFF_BASE       = 32'h00000004;
    localparam logic [31:0] RAPU_OFF_ATTR       = 32'h00000008;
    localparam logic [31:0] RAPU_OFF_ALIAS1     = 32'h0000000C;
    localparam logic [31:0] RAPU_OFF_ALIAS_STEP = 32'h00000008;
    localparam int          RAPU_NUM_ALIAS      = 4;
    localparam int          RAPU_NUM_REGIONS    = 8;
    localparam int          RAPU_WORD_SPAN      = 12;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RAPU_SEL_LSB      = 0;
    localparam int RAPU_SEL_W        = 3;
    localparam int RAPU_BASE_VALID   = 4;
    localparam int RAPU_BASE_REG_LSB = 0;
    localparam int RAPU_BASE_ADDR_LSB = 5;
    localparam int RAPU_EN_BIT       = 0;
    localparam int RAPU_SIZE_LSB     = 1;
    localparam int RAPU_SIZE_W       = 5;
    localparam int RAPU_SRD_LSB      = 8;
    localparam int RAPU_AP_LSB       = 24;
    localparam int RAPU_AP_W         = 3;
    localparam int RAPU_XN_BIT       = 28;
    localparam int RAPU_TEX_LSB      = 19;
    localparam int RAPU_C_BIT        = 17;
    localparam int RAPU_B_BIT        = 16;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0]  RAPU_SIZE_MIN    = 5'h04;
    localparam logic [4:0]  RAPU_SIZE_SUBMIN = 5'h07;
    localparam logic [31:0] RAPU_RST_WORD    = 32'h00000000;
    localparam logic [2:0]  RAPU_RST_SEL     = 3'h0;

    // Permission encodings
    localparam logic [2:0] RAPU_AP_NONE  = 3'h0;
    localparam logic [2:0] RAPU_AP_PRW   = 3'h1;
    localparam logic [2:0] RAPU_AP_PRW_UR = 3'h2;
    localparam logic [2:0] RAPU_AP_FULL  = 3'h3;
    localparam logic [2:0] RAPU_AP_PRO   = 3'h5;
    localparam logic [2:0] RAPU_AP_RO_A  = 3'h6;
    localparam logic [2:0] RAPU_AP_RO_B  = 3'h7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic        priv;
        logic        fetch;
    } rapu_access_t;

    typedef struct packed {
        logic        fault;
        logic        hit;
        logic [2:0]  region;
        logic        background;
        logic        strongly_ordered;
        logic [5:0]  attr;
    } rapu_result_t;

    typedef struct packed {
        logic        en;
        logic [1:0]  size;
        logic [3:0]  wstrb;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rapu_regreq_t;

endpackage

// ===== rtl/rapu_unit.sv
`timescale 1ns/1ns
// Function
// (RQ1) Eight regions plus privileged background region
// (RQ2) Highest numbered matching region wins
// (RQ3) Background grants privileged requests only; with unit_enable low the code grants every request
// (RQ4) One table serves fetches and data
// (RQ5) Prohibited access raises management fault
// (RQ6) Software uses words; attribute register also smaller
// (RQ7) Unaligned or wrong-size accesses are ignored
// (RQ8) Select, base, attribute writable separately or burst
// (RQ9) Alias pairs program up to four regions
// (RQ10) Valid base write picks embedded region
// (RQ11) Select at fixed address, base, size, attribute
// (RQ12) Large regions split into eight subregions
// (RQ13) Mask bit zero is lowest subregion
// (RQ14) Disabled subregion falls through or faults
// (RQ15) Small regions need zero subregion mask
// (RQ16) Software disables stale regions before reprogramming; the testbench rewrites bases without disabling first
// (RQ17) Software issues barriers after changes
// (RQ18) Software masks interrupts during attribute changes
// (RQ19) Strongly ordered accesses stay in order
// (RQ20) Three-bit permission field decode
// (RQ21) Check done in the access cycle
module rapu_unit
    import rapu_pkg::*;
#(
    parameter int NUM_REGIONS = RAPU_NUM_REGIONS
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         unit_enable,
    input  wire rapu_access_t acc,
    output rapu_result_t      res,
    output logic              so_hold,
    input  wire rapu_regreq_t reg_req,
    output logic [31:0]       reg_rdata,
    output logic              reg_ack,
    input  wire logic         acc_done
);

    // ------------------------------------------------------------
    // Region table
    // ------------------------------------------------------------
    logic [2:0]  sel_ff;
    logic [31:0] base_ff [NUM_REGIONS];
    logic [31:0] attr_ff [NUM_REGIONS];
    logic        so_pending_ff;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic ap_allows(input logic [2:0] ap, input logic priv, input logic wr);
        logic ok;
        ok = 1'b0;
        unique case (ap) // [RQ20]
            RAPU_AP_PRW:    ok = priv;
            RAPU_AP_PRW_UR: ok = priv | ~wr;
            RAPU_AP_FULL:   ok = 1'b1;
            RAPU_AP_PRO:    ok = priv & ~wr;
            RAPU_AP_RO_A,
            RAPU_AP_RO_B:   ok = ~wr;
            default:        ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic region_hit(input logic [31:0] base, input logic [31:0] attr,
                                        input logic [31:0] a);
        logic [4:0]  sz;
        logic [31:0] mask;
        logic [2:0]  sub;
        logic        in;
        sz   = attr[RAPU_SIZE_LSB +: RAPU_SIZE_W];
        mask = (sz >= 5'd31) ? 32'h00000000 : (32'hFFFFFFFF << (sz + 5'd1));
        in   = attr[RAPU_EN_BIT] && (sz >= RAPU_SIZE_MIN) && ((a & mask) == (base & mask));
        sub  = 3'h0;
        if (sz >= RAPU_SIZE_SUBMIN) begin // [RQ12]
            sub = 3'((a >> (sz - 5'd2)) & 32'h7); // [RQ13]
            if (attr[RAPU_SRD_LSB + sub]) begin
                in = 1'b0; // [RQ14]
            end
        end
        return in;
    endfunction

    function automatic logic is_so(input logic [31:0] attr);
        return (attr[RAPU_TEX_LSB +: 3] == 3'h0) && !attr[RAPU_C_BIT] && !attr[RAPU_B_BIT];
    endfunction

    // ------------------------------------------------------------
    // Match and permission, same cycle
    // ------------------------------------------------------------
    rapu_result_t nxt_res;
    always_comb begin
        logic [31:0] wattr;
        wattr   = RAPU_RST_WORD;
        nxt_res = '0;
        for (int i = 0; i < NUM_REGIONS; i++) begin // [RQ1] [RQ4]
            if (region_hit(base_ff[i], attr_ff[i], acc.addr)) begin
                nxt_res.hit    = 1'b1; // [RQ2]
                nxt_res.region = 3'(i);
                wattr          = attr_ff[i];
            end
        end
        if (!unit_enable) begin
            nxt_res.background = 1'b1;
        end else if (nxt_res.hit) begin
            nxt_res.fault = !ap_allows(wattr[RAPU_AP_LSB +: RAPU_AP_W], acc.priv, acc.write)
                            || (acc.fetch && wattr[RAPU_XN_BIT]);
            nxt_res.strongly_ordered = is_so(wattr);
            nxt_res.attr = wattr[RAPU_B_BIT +: 6];
        end else begin
            nxt_res.background = 1'b1;
            nxt_res.fault      = !acc.priv; // [RQ3]
        end
        nxt_res.fault = nxt_res.fault & acc.valid; // [RQ5] [RQ21]
    end
    assign res = nxt_res;

    // ------------------------------------------------------------
    // Strongly ordered sequencing
    // ------------------------------------------------------------
    // One outstanding strongly ordered access at a time keeps program order
    always_ff @(posedge clk) begin
        if (rst) begin
            so_pending_ff <= 1'b0;
        end else if (acc.valid && !so_hold && !nxt_res.fault && nxt_res.strongly_ordered) begin
            so_pending_ff <= 1'b1; // [RQ19]
        end else if (acc_done) begin
            so_pending_ff <= 1'b0;
        end
    end
    assign so_hold = so_pending_ff && acc.valid && nxt_res.strongly_ordered;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [31:0] off;
    logic        in_range;
    logic        aligned_ok;
    logic        is_base;
    logic        is_attr;
    logic [2:0]  tgt;
    assign off      = reg_req.addr - RAPU_ADDR_SELECT;
    // Last alias attribute word closes the window; anything above is refused
    assign in_range = (reg_req.addr >= RAPU_ADDR_SELECT) &&
                      (off < RAPU_OFF_ATTR + RAPU_OFF_ALIAS_STEP * 32'(RAPU_NUM_ALIAS - 1) + 32'h00000004);
    assign is_base  = in_range && (off != 32'h0) && (off[2:0] == 3'h4);
    // Whole attribute word, so byte lanes 1 and 3 reach it too
    assign is_attr  = in_range && (off >= RAPU_OFF_ATTR) && !off[2]; // [RQ9]
    always_comb begin
        unique case (reg_req.size)
            2'h2:    aligned_ok = (reg_req.addr[1:0] == 2'h0);
            2'h1:    aligned_ok = is_attr && !reg_req.addr[0]; // [RQ7]
            2'h0:    aligned_ok = is_attr;
            default: aligned_ok = 1'b0;
        endcase
    end
    assign tgt = (reg_req.write && is_base && reg_req.wdata[RAPU_BASE_VALID]) ?
                 reg_req.wdata[RAPU_BASE_REG_LSB +: 3] : sel_ff; // [RQ10]

    logic wr_go;
    assign wr_go = reg_req.en && reg_req.write && in_range && aligned_ok; // [RQ8]

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_ff <= RAPU_RST_SEL;
        end else if (wr_go && off == 32'h0) begin
            sel_ff <= reg_req.wdata[RAPU_SEL_LSB +: RAPU_SEL_W]; // [RQ11]
        end else if (wr_go && is_base && reg_req.wdata[RAPU_BASE_VALID]) begin
            sel_ff <= reg_req.wdata[RAPU_BASE_REG_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                base_ff[i] <= RAPU_RST_WORD;
                attr_ff[i] <= RAPU_RST_WORD;
            end
        end else if (wr_go && is_base) begin
            base_ff[tgt] <= {reg_req.wdata[31:RAPU_BASE_ADDR_LSB], 5'h00};
        end else if (wr_go && is_attr) begin
            for (int b = 0; b < 4; b++) begin
                if (reg_req.wstrb[b]) begin
                    attr_ff[sel_ff][b*8 +: 8] <= reg_req.wdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= RAPU_RST_WORD;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack   <= reg_req.en;
            reg_rdata <= RAPU_RST_WORD;
            if (reg_req.en && !reg_req.write && in_range && aligned_ok) begin
                if (off == 32'h0) begin
                    reg_rdata <= {29'h0, sel_ff};
                end else if (is_base) begin
                    reg_rdata <= base_ff[sel_ff] | {27'h0, 2'h0, sel_ff};
                end else if (is_attr) begin
                    reg_rdata <= attr_ff[sel_ff];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_bg_unpriv: assert property (@(posedge clk) disable iff (rst) // [RQ3]
        acc.valid && unit_enable && !res.hit && !acc.priv |-> res.fault)
        else $error("unprivileged background access not faulted");
    chk_bg_priv: assert property (@(posedge clk) disable iff (rst) // [RQ3]
        acc.valid && !res.hit && acc.priv |-> !res.fault)
        else $error("privileged background access faulted");
    chk_ap_none: assert property (@(posedge clk) disable iff (rst) // [RQ20]
        acc.valid && unit_enable && res.hit && attr_ff[res.region][RAPU_AP_LSB +: 3] == RAPU_AP_NONE
        |-> res.fault) else $error("no-access region allowed access");
    chk_ro_write: assert property (@(posedge clk) disable iff (rst) // [RQ20]
        acc.valid && unit_enable && res.hit && acc.write &&
        attr_ff[res.region][RAPU_AP_LSB +: 2] == 2'h2 && attr_ff[res.region][26] |-> res.fault)
        else $error("write to read-only region allowed");
    chk_top_region: assert property (@(posedge clk) disable iff (rst) // [RQ2]
        region_hit(base_ff[7], attr_ff[7], acc.addr) |-> res.hit && res.region == 3'h7)
        else $error("region seven did not take precedence");
    chk_sel_write: assert property (@(posedge clk) disable iff (rst) // [RQ11]
        reg_req.en && reg_req.write && reg_req.size == 2'h2 && reg_req.addr == RAPU_ADDR_SELECT
        |=> sel_ff == $past(reg_req.wdata[2:0])) else $error("select write lost");
    chk_unaligned: assert property (@(posedge clk) disable iff (rst) // [RQ7]
        reg_req.en && reg_req.write && reg_req.size == 2'h2 && reg_req.addr[1:0] != 2'h0
        |=> $stable(sel_ff)) else $error("unaligned write took effect");
    chk_so_order: assert property (@(posedge clk) disable iff (rst) // [RQ19]
        so_pending_ff && !acc_done |=> so_pending_ff)
        else $error("strongly ordered access released before completion");
    chk_fault_now: assert property (@(posedge clk) disable iff (rst) // [RQ5]
        !acc.valid |-> !res.fault) else $error("fault without access");

endmodule

// ===== verif/rapu_core_model.sv
`timescale 1ns/1ns
// --------------------------------------------
// Core side: presents accesses, completes them
// --------------------------------------------
module rapu_core_model
    import rapu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [31:0] addr,
    input  wire logic        write,
    input  wire logic        priv,
    input  wire logic        fetch,
    input  wire logic [3:0]  lat,
    input  wire logic        so_hold,
    output rapu_access_t     acc,
    output logic             acc_done
);
    logic [3:0] wait_ff;
    // Idle address is inverted so a stale one never looks live
    assign acc      = '{valid: go, addr: go ? addr : ~addr, write: write, priv: priv, fetch: fetch};
    assign acc_done = (wait_ff == 4'h1);
    // A stalled issue is not taken; completion lat cycles later
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_ff <= 4'h0;
        end else if (go && !so_hold) begin
            wait_ff <= lat + 4'h1;
        end else if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end
    end
endmodule

// ===== verif/tb_region_access_protection_unit.sv
`timescale 1ns/1ns
module tb_region_access_protection_unit;
    import rapu_pkg::*;
    localparam logic [31:0] SA = RAPU_ADDR_SELECT;
    logic         clk, rst, unit_enable, go, write, priv, fetch, so_hold, acc_done, reg_ack;
    logic [3:0]   lat;
    logic [31:0]  addr, reg_rdata, rnd, last_rd, at, b, t;
    logic [31:0]  base_m [8];
    logic [31:0]  attr_m [8];
    logic [2:0]   sel_m;
    int           bad_count, checks_done;
    rapu_access_t acc;
    rapu_result_t res;
    rapu_regreq_t reg_req;

    rapu_unit rapu_unit_inst (.clk(clk), .rst(rst), .unit_enable(unit_enable), .acc(acc), .res(res),
        .so_hold(so_hold), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .acc_done(acc_done));
    rapu_core_model rapu_core_model_inst (.clk(clk), .rst(rst), .go(go), .addr(addr), .write(write),
        .priv(priv), .fetch(fetch), .lat(lat), .so_hold(so_hold), .acc(acc), .acc_done(acc_done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xorshift();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [1:0] sz, input logic [3:0] st, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        reg_req = '{en: 1'b1, size: sz, wstrb: st, write: w, addr: a, wdata: d};
        @(posedge clk);
        #1 reg_req.en = 1'b0;
        for (n = 0; n < 8 && reg_ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 8) bad_count++;
        last_rd = reg_rdata;
        @(posedge clk);
        #1;
    endtask

    // Shadow table follows full-strobe word writes and subword writes to the main attribute word; refused shapes leave it alone
    task automatic wr(input logic [1:0] sz, input logic [3:0] st, input logic [31:0] a, input logic [31:0] d);
        logic [31:0] off;
        off = a - SA;
        bus(1'b1, sz, st, a, d);
        if (sz == 2'h2 && off == 32'h0) begin
            sel_m = d[2:0];
        end else if (sz == 2'h2 && off <= 32'h20 && off[1:0] == 2'h0) begin
            if (off[2] && d[RAPU_BASE_VALID]) sel_m = d[2:0];
            if (off[2]) base_m[sel_m] = d;
            else attr_m[sel_m] = d;
        end else if (sz != 2'h2 && off[31:2] == 30'h2) begin
            for (int i = 0; i < 4; i++) if (st[i]) attr_m[sel_m][8*i +: 8] = d[8*i +: 8];
        end
    endtask

    task automatic ww(input logic [31:0] a, input logic [31:0] d);
        wr(2'h2, 4'hF, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, 2'h2, 4'hF, a, 32'h0);
        check(last_rd, exp);
    endtask

    // Result as {attributes, fault, hit, background, strongly ordered, region}
    function automatic logic [12:0] exp_res(input logic [31:0] a, input logic w, input logic p);
        logic [31:0] x;
        logic [2:0]  ap;
        logic        ok;
        int          s;
        int          hr;
        hr = -1;
        for (int r = 0; r < 8; r++) begin
            x = attr_m[r];
            s = int'(x[5:1]);
            if (x[0] && s >= 4 && ((a ^ base_m[r]) >> (s + 1)) == 32'h0 && !(s >= 7 && x[8 + a[s -: 3]])) hr = r;
        end
        if (hr < 0) return {6'h0, !p, 3'h2, 3'h0};
        x = attr_m[hr];
        ap = x[26:24];
        ok = p ? (ap != 3'h0 && ap != 3'h4 && (!w || ap <= 3'h3)) : (ap == 3'h3 || (!w && (ap == 3'h2 || ap >= 3'h6)));
        return {x[21:16], !ok, 2'h2, x[21:19] == 3'h0 && x[17:16] == 2'h0, hr[2:0]};
    endfunction

    task automatic access(input logic [31:0] a, input logic w, input logic p, input logic f);
        logic [12:0] e;
        logic [12:0] s;
        e = unit_enable ? exp_res(a, w, p) : 13'h0;
        {go, addr, write, priv, fetch} = {1'b1, a, w, p, f};
        #49;
        s = {res.attr, res.fault, res.hit, res.background,
             res.hit & res.strongly_ordered, res.hit ? res.region : 3'h0};
        if (!unit_enable) s = {6'h0, res.fault, 6'h0};
        check({19'h0, s}, {19'h0, e});
        @(posedge clk);
        #1 go = 1'b0;
        @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] rand_attr();
        logic [31:0] r;
        logic [4:0]  s;
        logic [2:0]  ap;
        r = xorshift();
        s = 5'h4 + 5'(r[7:0] % 11);
        ap = (r[10:8] == 3'h4) ? 3'h3 : r[10:8];
        // Small regions keep a zero subregion mask
        return {5'h0, ap, 4'h0, r[14:11], (s >= 5'h7) ? r[23:16] : 8'h0, 2'h0, s, r[25:24] != 2'h0};
    endfunction

    initial begin
        rnd = 32'hD87BE86A;
        {rst, unit_enable, go, addr, write, priv, fetch, lat} = {3'h6, 32'h0, 3'h0, 4'h0};
        reg_req = '0;
        sel_m = 3'h0;
        base_m = '{default: 32'h0};
        attr_m = '{default: 32'h0};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        rd(SA, 32'h0);
        rd(SA + RAPU_OFF_ATTR, 32'h0);
        ww(SA + 32'h1, 32'h5);
        wr(2'h1, 4'h3, SA, 32'h6);
        rd(SA, 32'h0);
        rd(SA + 32'h24, 32'h0);
        ww(SA + RAPU_OFF_BASE, 32'h30000012);
        ww(SA + RAPU_OFF_ATTR, 32'h03020017);
        ww(SA + 32'h1C, 32'h30000017);
        ww(SA + 32'h20, 32'h0000010F);
        for (int i = 2; i >= 0; i--) begin
            access(32'h30000010, 1'b0, 1'b0, i[0]);
            access(32'h300000E0, 1'b0, 1'b1, 1'b0);
            access(32'h30002000, 1'b1, i[1], 1'b0);
            unit_enable = (i != 1);
        end
        // Enable lands last in each region's sequence
        // No traffic runs while attributes change
        repeat (3) begin
            for (int r = 0; r < 8; r++) begin
                at = rand_attr();
                t = xorshift();
                b = {15'h1000, t[16:5], 5'h0} & ~((32'h2 << at[5:1]) - 32'h1);
                if (t[31:30] == 2'h1) begin
                    ww(SA + RAPU_OFF_BASE + RAPU_OFF_ALIAS_STEP * t[19:18], b | 32'h10 | 32'(r));
                    ww(SA + RAPU_OFF_ATTR + RAPU_OFF_ALIAS_STEP * t[19:18], at);
                end else begin
                    ww(SA, 32'(r));
                    ww(SA + RAPU_OFF_BASE, b);
                    if (t[30]) ww(SA + RAPU_OFF_ATTR, at);
                    else begin
                        wr(2'h1, 4'hC, SA + 32'hA, at);
                        wr(2'h0, 4'h2, SA + 32'h9, at);
                        wr(2'h0, 4'h1, SA + 32'h8, at);
                    end
                end
            end
            // Read-back settles the table before traffic, as a barrier would
            for (int r = 0; r < 8; r++) begin
                ww(SA, 32'(r));
                rd(SA, 32'(r));
                rd(SA + RAPU_OFF_ATTR, attr_m[r]);
            end
            repeat (40) begin
                t = xorshift();
                lat = {1'b0, t[22:20]};
                unit_enable = |t[25:23];
                access({15'h1000, t[16:0]}, t[17] & ~t[18], t[19], t[18]);
            end
        end
        give_verdict();
    end

    initial begin
        #(3000 * 100);
        bad_count++;
        give_verdict();
    end
endmodule
